/* ifd_decoder.sv */
/*
 * Instruction format decoder with operand fetch and constant prefix.
 * Assumes a fetch path that offers one word per valid cycle and an
 * execution stage that writes results back and asks for address checks.
 */
// Functional notes
// RULE1: 32-bit words, each classed as three-register or register-constant
// RULE2: three-register form yields up to two sources and one destination
// RULE3: register-constant form yields one source and a 16-bit constant
// RULE4: constant after a prefix instruction widens to 32 bits using prefix
// RULE5: every register-constant instruction yields exactly one destination
// RULE6: unprefixed constant is sign extended by copying its top bit
// RULE7: load/store addresses aligned to byte, halfword or word size
// RULE8: each register selector picks one of 32 general registers
// RULE9: special moves give a separate special register selector
// RULE10: register file holds 32 registers of 32 bits
// RULE11: sorted into arithmetic, logical, branch, load/store, special
// RULE12: opcode 0-5, dest 6-10, src a 11-15, src b 16-20, const 16-31
// RULE13: register zero reads zero, writes to it are dropped
// RULE14: prefix held for exactly one following instruction, upper half
// RULE15: bit 0 of the instruction word is its most significant bit
`timescale 1ns/1ps
`include "ifd_params.svh"

module ifd_decoder
(
   // clock, reset, freeze
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire logic                      ce,
   // fetched instruction
   input  wire logic                      instr_valid,
   input  wire logic [`IFD_WORD_W-1:0]    instr_word,
   // result write back
   input  wire logic                      wb_en,
   input  wire logic [`IFD_SEL_W-1:0]     wb_sel,
   input  wire logic [`IFD_WORD_W-1:0]    wb_data,
   // load/store address check
   input  wire logic                      ls_req,
   input  wire logic [`IFD_WORD_W-1:0]    ls_addr,
   output logic                           ls_ack_r,
   output logic      [`IFD_WORD_W-1:0]    ls_addr_r,
   output logic                           ls_misalign_r,
   // decoded fields
   output logic                           dec_valid_r,
   output ifd_pkg::ifd_fmt_e              fmt_r,
   output ifd_pkg::ifd_cat_e              cat_r,
   output logic      [`IFD_OPC_W-1:0]     opcode_r,
   output logic      [`IFD_FUNC_W-1:0]    func_r,
   output logic      [`IFD_SEL_W-1:0]     dst_sel_r,
   output logic      [`IFD_SEL_W-1:0]     first_source_selector_r,
   output logic      [`IFD_SEL_W-1:0]     second_source_selector_r,
   output logic                           use_src_b_r,
   output logic      [`IFD_WORD_W-1:0]    imm_r,
   output logic                           imm_prefixed_r,
   output logic                           is_prefix_r,
   // special register moves
   output logic                           mts_r,
   output logic                           mfs_r,
   output logic                           special_destination_selector_r,
   output logic                           special_source_selector_r,
   // load/store size
   output logic                           is_ldst_r,
   output ifd_pkg::ifd_size_e             ls_size_r,
   // operand data
   output logic      [`IFD_WORD_W-1:0]    op_a_r,
   output logic      [`IFD_WORD_W-1:0]    op_b_r,
   output logic      [`IFD_WORD_W-1:0]    op_d_r
);

   // prefix tracker
   ifd_pkg::ifd_pfx_e        pfx_state_r;
   ifd_pkg::ifd_pfx_e        pfx_state_nxt;
   logic [`IFD_IMM_W-1:0]    pfx_val_r;

   // field extraction, bit 0 of the word is its MSB
   wire logic [`IFD_OPC_W-1:0]  f_opc  =
      instr_word[`IFD_OPC_MSB:`IFD_OPC_LSB]; // RULE12 RULE15
   wire logic [`IFD_SEL_W-1:0]  f_dst  =
      instr_word[`IFD_DST_MSB:`IFD_DST_LSB]; // RULE12
   wire logic [`IFD_SEL_W-1:0]  f_srca =
      instr_word[`IFD_SRCA_MSB:`IFD_SRCA_LSB]; // RULE12
   wire logic [`IFD_SEL_W-1:0]  f_srcb =
      instr_word[`IFD_SRCB_MSB:`IFD_SRCB_LSB]; // RULE12
   wire logic [`IFD_FUNC_W-1:0] f_func =
      instr_word[`IFD_FUNC_MSB:`IFD_FUNC_LSB]; // RULE12
   wire logic [`IFD_IMM_W-1:0]  f_imm  =
      instr_word[`IFD_IMM_MSB:`IFD_IMM_LSB]; // RULE12
   wire logic [1:0]             f_spm  = instr_word[`IFD_SPM_MSB:`IFD_SPM_LSB];

   // classification of the incoming word
   wire logic               take      = ce && instr_valid;
   wire logic               w_fmt_b   = instr_word[`IFD_FMT_BIT]; // RULE1
   wire logic               w_prefix  = (f_opc == `IFD_OPC_PREFIX);
   wire logic               w_spmove  = (f_opc == `IFD_OPC_SPMOVE);
   wire logic               w_mts     =
      w_spmove && (f_spm == `IFD_SPM_TO); // RULE9
   wire logic               w_mfs     =
      w_spmove && (f_spm == `IFD_SPM_FROM); // RULE9
   wire logic               w_ldst    = f_opc[5] && f_opc[4];
   wire logic               w_pfx_use = (pfx_state_r == ifd_pkg::IFD_PFX_HELD);
   wire ifd_pkg::ifd_cat_e  w_cat     = categorise(f_opc);
   wire ifd_pkg::ifd_size_e w_size    = size_of(f_opc[1:0]);

   // constant: prefixed upper half, otherwise sign extension
   wire logic [`IFD_WORD_W-1:0] w_imm = w_pfx_use ?
      {pfx_val_r, f_imm} : // RULE4 RULE14
      {{(`IFD_WORD_W-`IFD_IMM_W){f_imm[`IFD_IMM_W-1]}}, f_imm}; // RULE6

   // register operands read from the file
   logic [`IFD_WORD_W-1:0] rf_a;
   logic [`IFD_WORD_W-1:0] rf_b;
   logic [`IFD_WORD_W-1:0] rf_d;

   // address check on the current decoded size
   wire logic [`IFD_WORD_W-1:0] w_ls_aligned = align_addr(ls_addr, ls_size_r);
   wire logic w_ls_bad = (w_ls_aligned != ls_addr);

   // sort opcode into its functional category
   function automatic ifd_pkg::ifd_cat_e categorise
   (
      input logic [`IFD_OPC_W-1:0] opc
   );
      unique case (opc[5:4])
         2'h0:    categorise = ifd_pkg::IFD_CAT_ARITH;
         2'h1:    categorise = (opc == `IFD_OPC_STREAM) ?
                     ifd_pkg::IFD_CAT_SPECIAL : ifd_pkg::IFD_CAT_ARITH;
         2'h2:
         begin
            if ((opc == `IFD_OPC_BR_UNC) || (opc == `IFD_OPC_BR_CND) ||
                (opc == `IFD_OPC_RET) || (opc == `IFD_OPC_BRI_UNC) ||
                (opc == `IFD_OPC_BRI_CND))
               categorise = ifd_pkg::IFD_CAT_BRANCH;
            else if ((opc == `IFD_OPC_SPMOVE) || (opc == `IFD_OPC_PREFIX))
               categorise = ifd_pkg::IFD_CAT_SPECIAL;
            else
               categorise = ifd_pkg::IFD_CAT_LOGIC;
         end
         2'h3:    categorise = ifd_pkg::IFD_CAT_LDST;
      endcase
   endfunction

   // datum size from the low opcode bits
   function automatic ifd_pkg::ifd_size_e size_of
   (
      input logic [1:0] code
   );
      unique case (code)
         2'h0:    size_of = ifd_pkg::IFD_SZ_BYTE;
         2'h1:    size_of = ifd_pkg::IFD_SZ_HALF;
         default: size_of = ifd_pkg::IFD_SZ_WORD;
      endcase
   endfunction

   // clear the low address bits below the datum size
   function automatic logic [`IFD_WORD_W-1:0] align_addr
   (
      input logic [`IFD_WORD_W-1:0] addr,
      input ifd_pkg::ifd_size_e     sz
   );
      unique case (sz)
         ifd_pkg::IFD_SZ_BYTE: align_addr = addr;
         ifd_pkg::IFD_SZ_HALF: align_addr = {addr[`IFD_WORD_W-1:1], 1'b0};
         default:              align_addr = {addr[`IFD_WORD_W-1:2], 2'h0};
      endcase
   endfunction

   // general register file
   ifd_regfile u_regfile
   (
      .mclk      (mclk),
      .ce        (ce),
      .wr_en     (wb_en),
      .wr_sel    (wb_sel),
      .wr_data   (wb_data),
      .rd_a_sel  (f_srca),
      .rd_b_sel  (f_srcb),
      .rd_d_sel  (f_dst),
      .rd_a_data (rf_a),
      .rd_b_data (rf_b),
      .rd_d_data (rf_d)
   );

   // prefix tracker: one instruction of lifetime
   always_comb
   begin
      pfx_state_nxt = pfx_state_r;
      if (take)
         pfx_state_nxt = w_prefix ? ifd_pkg::IFD_PFX_HELD : // RULE14
                                    ifd_pkg::IFD_PFX_NONE;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pfx_state_r <= ifd_pkg::IFD_PFX_NONE;
         pfx_val_r   <= '0;
      end
      else if (take)
      begin
         pfx_state_r <= pfx_state_nxt;
         if (w_prefix)
            pfx_val_r <= f_imm; // RULE4
      end
   end

   // decode valid pulse
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         dec_valid_r <= 1'b0;
      else if (ce)
         dec_valid_r <= instr_valid;
   end

   // format, category and fields
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fmt_r                    <= ifd_pkg::IFD_FMT_REG3;
         cat_r                    <= ifd_pkg::IFD_CAT_ARITH;
         opcode_r                 <= '0;
         func_r                   <= '0;
         dst_sel_r                <= `IFD_RST_SEL;
         first_source_selector_r  <= `IFD_RST_SEL;
         second_source_selector_r <= `IFD_RST_SEL;
         use_src_b_r              <= 1'b0;
         is_prefix_r              <= 1'b0;
      end
      else if (take)
      begin
         fmt_r <= w_fmt_b ? ifd_pkg::IFD_FMT_REGIMM :
                            ifd_pkg::IFD_FMT_REG3; // RULE1
         cat_r                    <= w_cat; // RULE11
         opcode_r                 <= f_opc;
         func_r                   <= w_fmt_b ? '0 : f_func; // RULE2
         dst_sel_r                <= f_dst; // RULE5 RULE8
         first_source_selector_r  <= f_srca; // RULE2 RULE3
         second_source_selector_r <= w_fmt_b ? `IFD_RST_SEL : f_srcb;
         use_src_b_r              <= !w_fmt_b; // RULE2
         is_prefix_r              <= w_prefix;
      end
   end

   // constant operand
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         imm_r          <= `IFD_RST_WORD;
         imm_prefixed_r <= 1'b0;
      end
      else if (take)
      begin
         imm_r          <= w_fmt_b ? w_imm : `IFD_RST_WORD; // RULE3
         imm_prefixed_r <= w_fmt_b && w_pfx_use;
      end
   end

   // special moves and load/store size
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mts_r                          <= 1'b0;
         mfs_r                          <= 1'b0;
         special_destination_selector_r <= 1'b0;
         special_source_selector_r      <= 1'b0;
         is_ldst_r                      <= 1'b0;
         ls_size_r                      <= ifd_pkg::IFD_SZ_WORD;
      end
      else if (take)
      begin
         mts_r <= w_mts;
         mfs_r <= w_mfs;
         special_destination_selector_r <=
            w_mts && instr_word[`IFD_SPR_BIT]; // RULE9
         special_source_selector_r <=
            w_mfs && instr_word[`IFD_SPR_BIT]; // RULE9
         is_ldst_r <= w_ldst;
         if (w_ldst)
            ls_size_r <= w_size;
      end
   end

   // operand data, zero register forced by the file
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_a_r <= `IFD_RST_WORD;
         op_b_r <= `IFD_RST_WORD;
         op_d_r <= `IFD_RST_WORD;
      end
      else if (take)
      begin
         op_a_r <= rf_a; // RULE13
         op_b_r <= w_fmt_b ? w_imm : rf_b;
         op_d_r <= rf_d;
      end
   end

   // aligned address answer one cycle after the request
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ls_ack_r      <= 1'b0;
         ls_addr_r     <= `IFD_RST_WORD;
         ls_misalign_r <= 1'b0;
      end
      else if (ce)
      begin
         ls_ack_r <= ls_req;
         if (ls_req)
         begin
            ls_addr_r     <= w_ls_aligned; // RULE7
            ls_misalign_r <= w_ls_bad;
         end
      end
   end

   a_fmt_class: assert property (@(posedge mclk) disable iff (!rst_n)
      take |=> (fmt_r == ($past(instr_word[`IFD_FMT_BIT]) ?
         ifd_pkg::IFD_FMT_REGIMM : ifd_pkg::IFD_FMT_REG3))) // RULE1
      else $error("format class wrong");

   a_field_pos: assert property (@(posedge mclk) disable iff (!rst_n)
      take |=> (dst_sel_r == $past(instr_word[25:21])) &&
         (first_source_selector_r == $past(instr_word[20:16])) &&
         (opcode_r == $past(instr_word[31:26]))) // RULE12
      else $error("field position wrong");

   a_src_b_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && !w_fmt_b) |=> use_src_b_r &&
         (second_source_selector_r == $past(instr_word[15:11]))) // RULE2
      else $error("second source not taken");

   a_sign_ext: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && w_fmt_b && !w_pfx_use) |=>
         (imm_r[31:16] == {16{$past(instr_word[15])}}) &&
         (imm_r[15:0] == $past(instr_word[15:0]))) // RULE6
      else $error("constant not sign extended");

   a_prefix_widen: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && w_fmt_b && w_pfx_use) |=>
         imm_prefixed_r && (imm_r[31:16] == $past(pfx_val_r))) // RULE4
      else $error("prefix not placed in upper half");

   a_prefix_once: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && w_pfx_use && !w_prefix) |=>
         (pfx_state_r == ifd_pkg::IFD_PFX_NONE)) // RULE14
      else $error("prefix held past one instruction");

   a_zero_oper: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && (f_srca == `IFD_RST_SEL)) |=>
         (op_a_r == `IFD_RST_WORD)) // RULE13
      else $error("zero register operand nonzero");

   a_branch_cat: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && (f_opc == `IFD_OPC_BR_CND)) |=>
         (cat_r == ifd_pkg::IFD_CAT_BRANCH) && !is_ldst_r) // RULE11
      else $error("branch category wrong");

   a_spr_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      (take && w_mts) |=> mts_r && !mfs_r &&
         (special_destination_selector_r == $past(instr_word[0]))) // RULE9
      else $error("special selector wrong");

   a_ls_align: assert property (@(posedge mclk) disable iff (!rst_n)
      (ce && ls_req && (ls_size_r == ifd_pkg::IFD_SZ_WORD)) |=>
         ls_ack_r && (ls_addr_r[1:0] == 2'h0) &&
         (ls_misalign_r == ($past(ls_addr[1:0]) != 2'h0))) // RULE7
      else $error("word address not aligned");

endmodule

/* ifd_fetch_model.sv */
/*
 * fetch-path model: offers one 32-bit instruction word per call.
 * assumes send is entered at a falling edge of mclk.
 */
`timescale 1ns/1ps
`include "ifd_params.svh"

module ifd_fetch_model
(
   // clock
   input  wire logic                    mclk,
   // instruction offer
   output logic                         instr_valid,
   output logic [`IFD_WORD_W-1:0]       instr_word
);
   // idle at time zero
   initial
   begin
      instr_valid = 1'b0;
      instr_word  = 32'h0000_0000;
   end

   // offer a word for one edge; a released bus shows the inverse
   task automatic send(input logic [`IFD_WORD_W-1:0] w, input bit keep);
      instr_valid <= 1'b1;
      instr_word  <= w;
      @(negedge mclk);
      if (!keep)
      begin
         instr_valid <= 1'b0;
         instr_word  <= ~w;
         @(negedge mclk); // one idle edge before the next offer
      end
   endtask
endmodule

/* ifd_params.svh */
/*
 * Field positions, opcode codes and widths for the instruction decoder.
 * Assumes the includer counts bits with 31 as the MSB of the word; the
 * instruction numbering (bit 0 = MSB) maps to index 31 - n.
 */
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH

// word and register file geometry
`define IFD_WORD_W      32
`define IFD_SEL_W       5
`define IFD_NUM_REGS    32
`define IFD_IMM_W       16
`define IFD_FUNC_W      11
`define IFD_OPC_W       6

// field positions (instruction bits 0-5, 6-10, 11-15, 16-20, 21-31, 16-31)
`define IFD_OPC_MSB     31
`define IFD_OPC_LSB     26
`define IFD_DST_MSB     25
`define IFD_DST_LSB     21
`define IFD_SRCA_MSB    20
`define IFD_SRCA_LSB    16
`define IFD_SRCB_MSB    15
`define IFD_SRCB_LSB    11
`define IFD_FUNC_MSB    10
`define IFD_FUNC_LSB    0
`define IFD_IMM_MSB     15
`define IFD_IMM_LSB     0
// opcode bit that marks the register-plus-constant format (instr bit 2)
`define IFD_FMT_BIT     29
// special move: instr bits 16-17 and the selector bit (bit 31)
`define IFD_SPM_MSB     15
`define IFD_SPM_LSB     14
`define IFD_SPR_BIT     0

// opcodes that are decoded by value
`define IFD_OPC_PREFIX  6'h2C
`define IFD_OPC_SPMOVE  6'h25
`define IFD_OPC_STREAM  6'h1B
`define IFD_OPC_BR_UNC  6'h26
`define IFD_OPC_BR_CND  6'h27
`define IFD_OPC_RET     6'h2D
`define IFD_OPC_BRI_UNC 6'h2E
`define IFD_OPC_BRI_CND 6'h2F
`define IFD_SPM_TO      2'h3
`define IFD_SPM_FROM    2'h2

// reset values
`define IFD_RST_WORD    32'h0000_0000
`define IFD_RST_SEL     5'h00

`endif

/* ifd_pkg.sv */
/*
 * Types shared by the decoder and its testbench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ifd_pkg;

   // instruction format
   typedef enum logic {IFD_FMT_REG3, IFD_FMT_REGIMM} ifd_fmt_e;

   // functional category
   typedef enum logic [2:0]
   {
      IFD_CAT_ARITH,
      IFD_CAT_LOGIC,
      IFD_CAT_BRANCH,
      IFD_CAT_LDST,
      IFD_CAT_SPECIAL
   } ifd_cat_e;

   // datum size of a load or store
   typedef enum logic [1:0] {IFD_SZ_BYTE, IFD_SZ_HALF, IFD_SZ_WORD} ifd_size_e;

   // prefix tracker states
   typedef enum logic {IFD_PFX_NONE, IFD_PFX_HELD} ifd_pfx_e;

endpackage

/* ifd_regfile.sv */
/*
 * Thirty-two by 32-bit general register file, three read ports, one write.
 * Assumes reads are combinational and the caller registers the data; a
 * read and write of the same register in one cycle returns the old value.
 */
`timescale 1ns/1ps
`include "ifd_params.svh"

module ifd_regfile
(
   // clock and freeze
   input  wire logic                      mclk,
   input  wire logic                      ce,
   // write port
   input  wire logic                      wr_en,
   input  wire logic [`IFD_SEL_W-1:0]     wr_sel,
   input  wire logic [`IFD_WORD_W-1:0]    wr_data,
   // read ports
   input  wire logic [`IFD_SEL_W-1:0]     rd_a_sel,
   input  wire logic [`IFD_SEL_W-1:0]     rd_b_sel,
   input  wire logic [`IFD_SEL_W-1:0]     rd_d_sel,
   output logic      [`IFD_WORD_W-1:0]    rd_a_data,
   output logic      [`IFD_WORD_W-1:0]    rd_b_data,
   output logic      [`IFD_WORD_W-1:0]    rd_d_data
);

   logic [`IFD_WORD_W-1:0] mem [`IFD_NUM_REGS]; // RULE10

   // zero register reads as zero whatever the array holds; the word comes
   // in as an argument so the read port follows writes to a held selector
   function automatic logic [`IFD_WORD_W-1:0] rd_port
   (
      input logic [`IFD_SEL_W-1:0]  sel,
      input logic [`IFD_WORD_W-1:0] word
   );
      rd_port = (sel == `IFD_RST_SEL) ? `IFD_RST_WORD : word; // RULE13
   endfunction

   // writes to the zero register are dropped
   always_ff @(posedge mclk)
   begin
      if (ce && wr_en && (wr_sel != `IFD_RST_SEL)) // RULE13
         mem[wr_sel] <= wr_data;
   end

   // read decode
   assign rd_a_data = rd_port(rd_a_sel, mem[rd_a_sel]); // RULE8
   assign rd_b_data = rd_port(rd_b_sel, mem[rd_b_sel]);
   assign rd_d_data = rd_port(rd_d_sel, mem[rd_d_sel]);

   a_zero_read: assert property (@(posedge mclk)
      (rd_a_sel == `IFD_RST_SEL) |-> (rd_a_data == `IFD_RST_WORD)) // RULE13
      else $error("zero register read returned nonzero");

endmodule

/* instruction_format_decoder_tb.sv */
/*
 * self-checking bench for the instruction decoder.
 * assumes the fetch model file and the design files are compiled first.
 */
`timescale 1ns/1ps
`include "ifd_params.svh"

module instruction_format_decoder_tb;
   logic               mclk, rst_n, ce, wb_en, ls_req, instr_valid;
   logic        [31:0] instr_word, wb_data, ls_addr, ls_addr_r, imm_r;
   logic        [31:0] op_a_r, op_b_r, op_d_r;
   logic         [4:0] wb_sel, dst_sel_r;
   logic         [4:0] first_source_selector_r, second_source_selector_r;
   logic         [5:0] opcode_r;
   logic        [10:0] func_r;
   logic               ls_ack_r, ls_misalign_r, dec_valid_r, use_src_b_r;
   logic               imm_prefixed_r, is_prefix_r, mts_r, mfs_r, is_ldst_r;
   logic               special_destination_selector_r;
   logic               special_source_selector_r;
   ifd_pkg::ifd_fmt_e  fmt_r;
   ifd_pkg::ifd_cat_e  cat_r;
   ifd_pkg::ifd_size_e ls_size_r;
   int                 miscompares, num_checks;

   ifd_decoder ifd_decoder_inst
   (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid),
      .instr_word(instr_word), .wb_en(wb_en), .wb_sel(wb_sel),
      .wb_data(wb_data), .ls_req(ls_req), .ls_addr(ls_addr),
      .ls_ack_r(ls_ack_r), .ls_addr_r(ls_addr_r),
      .ls_misalign_r(ls_misalign_r), .dec_valid_r(dec_valid_r),
      .fmt_r(fmt_r), .cat_r(cat_r), .opcode_r(opcode_r), .func_r(func_r),
      .dst_sel_r(dst_sel_r),
      .first_source_selector_r(first_source_selector_r),
      .second_source_selector_r(second_source_selector_r),
      .use_src_b_r(use_src_b_r), .imm_r(imm_r),
      .imm_prefixed_r(imm_prefixed_r), .is_prefix_r(is_prefix_r),
      .mts_r(mts_r), .mfs_r(mfs_r),
      .special_destination_selector_r(special_destination_selector_r),
      .special_source_selector_r(special_source_selector_r),
      .is_ldst_r(is_ldst_r), .ls_size_r(ls_size_r),
      .op_a_r(op_a_r), .op_b_r(op_b_r), .op_d_r(op_d_r)
   );

   ifd_fetch_model ifd_fetch_model_inst
   (
      .mclk(mclk), .instr_valid(instr_valid), .instr_word(instr_word)
   );

   // clock, 4 ns period
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // instruction word from fields
   function automatic logic [31:0] mk(input logic [5:0] o,
      input logic [4:0] d, input logic [4:0] a, input logic [15:0] k);
      return {o, d, a, k};
   endfunction

   task automatic snd(input logic [31:0] w, input bit keep);
      ifd_fetch_model_inst.send(w, keep);
   endtask

   // one write back cycle
   task automatic wr(input logic [4:0] s, input logic [31:0] d);
      wb_en   = 1'b1;
      wb_sel  = s;
      wb_data = d;
      @(negedge mclk);
   endtask

   // three-register form, register file, zero register
   task automatic t_reg3();
      wr(5'h05, 32'hA5A5_0F0F);
      wr(5'h1F, 32'h1234_5678);
      wr(5'h00, 32'hFFFF_FFFF);
      wb_en = 1'b0;
      snd(mk(6'h00, 5'h03, 5'h05, {5'h1F, 11'h000}), 1);
      chk(dec_valid_r, 1'b1);
      chk(fmt_r, ifd_pkg::IFD_FMT_REG3);
      chk(dst_sel_r, 5'h03);
      chk(first_source_selector_r, 5'h05);
      chk(second_source_selector_r, 5'h1F);
      chk(use_src_b_r, 1'b1);
      chk(op_a_r, 32'hA5A5_0F0F);
      chk(op_b_r, 32'h1234_5678);
      snd(mk(6'h00, 5'h1F, 5'h00, 16'h07FF), 0);
      chk(op_a_r, 32'h0000_0000);
      chk(op_b_r, 32'h0000_0000);
      chk(op_d_r, 32'h1234_5678);
      chk(func_r, 11'h7FF);
      @(negedge mclk);
      chk(dec_valid_r, 1'b0);
      $display("test reg3 done");
   endtask

   // constant form with and without prefix
   task automatic t_const();
      snd(mk(6'h08, 5'h04, 5'h05, 16'h8001), 0);
      chk(fmt_r, ifd_pkg::IFD_FMT_REGIMM);
      chk(dst_sel_r, 5'h04);
      chk(op_a_r, 32'hA5A5_0F0F);
      chk(imm_r, 32'hFFFF_8001);
      chk(op_b_r, 32'hFFFF_8001);
      chk(imm_prefixed_r, 1'b0);
      snd(mk(6'h2C, 5'h00, 5'h00, 16'h1234), 0);
      @(negedge mclk);
      chk(is_prefix_r, 1'b1);
      snd(mk(6'h08, 5'h04, 5'h05, 16'h8001), 0);
      chk(imm_r, 32'h1234_8001);
      chk(imm_prefixed_r, 1'b1);
      snd(mk(6'h08, 5'h04, 5'h05, 16'h7FFF), 0);
      chk(imm_r, 32'h0000_7FFF);
      snd(mk(6'h2C, 5'h00, 5'h00, 16'h5555), 1);
      snd(mk(6'h00, 5'h02, 5'h01, 16'h0000), 1);
      snd(mk(6'h08, 5'h04, 5'h05, 16'h8001), 0);
      chk(imm_prefixed_r, 1'b0);
      snd(mk(6'h2C, 5'h00, 5'h00, 16'h1111), 1);
      snd(mk(6'h2C, 5'h00, 5'h00, 16'h2222), 1);
      snd(mk(6'h08, 5'h04, 5'h05, 16'h0001), 0);
      chk(imm_r, 32'h2222_0001);
      $display("test const done");
   endtask

   // special moves and clock enable freeze
   task automatic t_special();
      snd(mk(6'h25, 5'h00, 5'h02, 16'hC001), 0);
      chk(mts_r, 1'b1);
      chk(special_destination_selector_r, 1'b1);
      chk(cat_r, ifd_pkg::IFD_CAT_SPECIAL);
      snd(mk(6'h25, 5'h07, 5'h00, 16'h8001), 1);
      chk(mfs_r, 1'b1);
      chk(mts_r, 1'b0);
      chk(special_source_selector_r, 1'b1);
      ce = 1'b0;
      snd(mk(6'h00, 5'h09, 5'h01, 16'h0000), 0);
      chk(dec_valid_r, 1'b1);
      chk(dst_sel_r, 5'h07);
      ce = 1'b1;
      $display("test special done");
   endtask

   // categories, format bit and load/store flag over a table
   task automatic t_cat();
      logic [5:0] opc [11];
      logic [2:0] cat [11];
      opc = '{6'h00, 6'h12, 6'h18, 6'h20, 6'h2A, 6'h26, 6'h2D, 6'h2F,
              6'h36, 6'h1B, 6'h25};
      cat = '{0, 0, 0, 1, 1, 2, 2, 2, 3, 4, 4};
      for (int i = 0; i < 11; i++)
      begin
         snd(mk(opc[i], 5'h02, 5'h01, 16'h0000), 0);
         chk(cat_r, cat[i]);
         chk(opcode_r, opc[i]);
         chk(fmt_r, opc[i][3]);
         chk(is_ldst_r, opc[i][5:4] == 2'b11);
      end
      $display("test categories done");
   endtask

   // address alignment for byte, halfword and word
   task automatic t_align();
      logic [31:0] a;
      logic [31:0] m;
      for (int i = 0; i < 4; i++)
      begin
         a = (i == 3) ? 32'h0000_0104 : 32'h0000_0103;
         m = (i == 0) ? 32'h0 : ((i == 1) ? 32'h1 : 32'h3);
         snd(mk(6'('h30 + ((i > 2) ? 2 : i)), 5'h02, 5'h01, 16'h0000), 0);
         chk(ls_size_r, (i > 2) ? 2 : i);
         ls_req  = 1'b1;
         ls_addr = a;
         @(negedge mclk);
         ls_req  = 1'b0;
         ls_addr = ~a;
         chk(ls_ack_r, 1'b1);
         chk(ls_addr_r, a & ~m);
         chk(ls_misalign_r, |(a & m));
      end
      $display("test align done");
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      rst_n   = 1'b0;
      ce      = 1'b1;
      wb_en   = 1'b0;
      wb_sel  = 5'h00;
      wb_data = 32'h0000_0000;
      ls_req  = 1'b0;
      ls_addr = 32'h0000_0000;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      t_reg3();
      t_const();
      t_special();
      t_cat();
      t_align();
      tally_and_finish();
   end
endmodule
